// ---- include/core_irq_defs.vh ----
// constants for the core interrupt, program counter, stack and indirect block
`ifndef CORE_IRQ_DEFS_VH
`define CORE_IRQ_DEFS_VH
// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define IDX_WINDOW     8'h00
`define IDX_PC_LOW     8'h02
`define IDX_POINTER    8'h04
`define IDX_PC_HIGH    8'h0A
`define IDX_IRQ_CTRL   8'h0B
`define IDX_PFLAG      8'h0C
`define IDX_OPTION     8'h81
`define IDX_PENABLE    8'h8C
`define IDX_PINSTATE   8'h91
// ----------------------------------------
// irq_control field positions
// ----------------------------------------
`define GLOBAL_EN_BIT   7
`define PERIPH_EN_BIT   6
`define TIMER_EN_BIT    5
`define EXT_EN_BIT      4
`define CHANGE_EN_BIT   3
`define TIMER_FLAG_BIT  2
`define EXT_FLAG_BIT    1
`define CHANGE_FLAG_BIT 0
// option register fields
`define EDGE_SEL_BIT   6
`define PULLUP_OFF_BIT 7
// ----------------------------------------
// reset values and fixed addresses
// ----------------------------------------
`define IRQ_CTRL_RESET 8'h00
`define OPTION_RESET   8'hFF
`define BYTE_ZERO      8'h00
`define PC_RESET       13'h0000
`define IRQ_VECTOR     13'h0004
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10
`endif

// ---- verilog/core_irq_pc_stack_indirect.v ----
// core control: interrupt flags and gate, program counter, return stack, indirect access
// Contract
// - global enable bit 7 gates all interrupts
// - peripheral enable bit 6 gates peripheral interrupts
// - timer overflow sets bit 2; enable bit 5
// - external edge sets bit 1; enable bit 4
// - pin change sets bit 0; enable bit 3
// - flags set regardless of any enable
// - bits 7..1 reset zero, all read/write
// - pc 13 bits, low byte accessible only
// - every reset clears whole program counter
// - low byte write loads upper from holding<4:0>
// - call/jump use holding bits 4 and 3
// - paging bits load pc<12:11>, single page device
// - eight 13-bit entries, hidden pointer
// - push on call/irq, pop on returns
// - push and pop leave holding register alone
// - stack wraps as circular buffer
// - no overflow or underflow status
// - pointer zero: read 00h, write ignored
// - effective address is bank bit plus pointer
// - pin change covers three pins together
// - clear-pin mode: no change, reads 0, pullup
// - edge select picks rising or falling
`timescale 1ns/1ps
`default_nettype none
`include "core_irq_defs.vh"

module core_irq_pc_stack_indirect (
   input  wire        clk_sys,
   input  wire        reset,
   // axi4-lite slave
   input  wire [31:0] awaddr,
   input  wire [2:0]  awprot,
   input  wire        awvalid,
   output reg         awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output reg         wready,
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   input  wire [31:0] araddr,
   input  wire [2:0]  arprot,
   input  wire        arvalid,
   output reg         arready,
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   // instruction side strobes, one cycle each
   input  wire        instr_step,
   input  wire        call_instr,
   input  wire        jump_instr,
   input  wire        return_instr,
   input  wire        return_literal_instr,
   input  wire        return_from_irq_instr,
   input  wire        irq_take,
   input  wire [10:0] branch_target,
   // event sources
   input  wire        timer_ovf_event,
   input  wire [7:0]  periph_flag_set,
   input  wire        ext_irq_pin,
   input  wire        pin_zero,
   input  wire        pin_one,
   input  wire        pin_three,
   input  wire        master_clear_select,
   // core outputs
   output reg  [12:0] pc_value,
   output reg         irq_request,
   output reg  [2:0]  weak_pullup_enable
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg  [7:0]  irq_control_reg;         // enables and event flags
   reg  [7:0]  periph_flag_reg;         // peripheral event flags
   reg  [7:0]  periph_enable_reg;       // peripheral enables
   reg  [7:0]  option_reg;              // edge select and pull-up control
   reg  [4:0]  pc_high_holding_reg;     // upper pc staging, bits 7..5 read 0
   reg  [7:0]  indirect_pointer_reg;    // indirect address low byte
   reg  [12:0] pc_reg;                  // program counter
   reg  [12:0] stack_mem [0:7];         // return stack entries
   reg  [2:0]  stack_ptr_reg;           // next free slot, not visible to software
   reg         ext_prev_reg;            // last sample of external pin
   reg  [2:0]  pins_prev_reg;           // last sample of change pins
   reg         primed_reg;              // first sample taken after reset
   // bus capture
   reg         aw_full_reg;
   reg         w_full_reg;
   reg  [31:0] aw_addr_reg;
   reg  [7:0]  w_data_reg;
   reg         w_lane_reg;              // low byte lane enabled
   integer     i;

   // ----------------------------------------
   // helper functions
   // ----------------------------------------
   // index from a byte address; upper bits must be zero to be mapped
   function addr_ok;
      input [31:0] a;
      begin
         addr_ok = (a[31:10] == 22'h00_0000);
      end
   endfunction

   // whether an index names a register
   function idx_mapped;
      input [7:0] idx;
      begin
         case (idx)
            `IDX_WINDOW, `IDX_PC_LOW, `IDX_POINTER, `IDX_PC_HIGH, `IDX_IRQ_CTRL,
            `IDX_PFLAG, `IDX_OPTION, `IDX_PENABLE, `IDX_PINSTATE: idx_mapped = 1'b1;
            default: idx_mapped = 1'b0;
         endcase
      end
   endfunction

   // window resolves to the pointer; bank bit is constant zero so it drops out
   function [7:0] eff_idx;
      input [7:0] idx;
      begin
         eff_idx = (idx == `IDX_WINDOW) ? indirect_pointer_reg : idx;
      end
   endfunction

   // read value of a resolved index; window itself and holes read zero
   function [7:0] reg_value;
      input [7:0] idx;
      begin
         case (idx)
            `IDX_PC_LOW:   reg_value = pc_reg[7:0];
            `IDX_POINTER:  reg_value = indirect_pointer_reg;
            `IDX_PC_HIGH:  reg_value = {3'b000, pc_high_holding_reg};
            `IDX_IRQ_CTRL: reg_value = irq_control_reg;
            `IDX_PFLAG:    reg_value = periph_flag_reg;
            `IDX_OPTION:   reg_value = option_reg;
            `IDX_PENABLE:  reg_value = periph_enable_reg;
            `IDX_PINSTATE: reg_value = {4'b0000, pin_three & ~master_clear_select,
                                        1'b0, pin_one, pin_zero};
            default:       reg_value = `BYTE_ZERO;
         endcase
      end
   endfunction

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   wire [7:0] wr_idx    = aw_addr_reg[9:2];
   wire       wr_fire   = aw_full_reg & w_full_reg & ~bvalid;
   wire       wr_ok     = addr_ok(aw_addr_reg) & idx_mapped(wr_idx);
   wire [7:0] wr_eff    = eff_idx(wr_idx);
   // a write through a zero pointer lands on the window index and stores nothing
   wire       wr_en     = wr_fire & wr_ok & w_lane_reg;
   wire       wr_ctrl   = wr_en & (wr_eff == `IDX_IRQ_CTRL);
   wire       wr_pflag  = wr_en & (wr_eff == `IDX_PFLAG);
   wire       wr_pc_low = wr_en & (wr_eff == `IDX_PC_LOW);
   wire [7:0] rd_idx    = araddr[9:2];
   wire       rd_ok     = addr_ok(araddr) & idx_mapped(rd_idx);

   // ----------------------------------------
   // event detection
   // ----------------------------------------
   // pin three drops out of the change set in clear-pin mode
   wire [2:0] pins_now  = {pin_three & ~master_clear_select, pin_one, pin_zero};
   wire       pin_chg   = primed_reg & (pins_now != pins_prev_reg);
   wire       ext_rise  = ext_irq_pin & ~ext_prev_reg;
   wire       ext_fall  = ~ext_irq_pin & ext_prev_reg;
   wire       ext_evt   = primed_reg &
                          (option_reg[`EDGE_SEL_BIT] ? ext_rise : ext_fall);
   wire       do_return = return_instr | return_literal_instr | return_from_irq_instr;
   wire [2:0] sp_dec    = stack_ptr_reg - 3'd1;

   // ----------------------------------------
   // axi write channels
   // ----------------------------------------
   // address and data are held until both arrive, in either order
   always @(posedge clk_sys) begin
      if (reset) begin
         awready     <= 1'b0;
         wready      <= 1'b0;
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         aw_addr_reg <= 32'h0000_0000;
         w_data_reg  <= `BYTE_ZERO;
         w_lane_reg  <= 1'b0;
         bvalid      <= 1'b0;
         bresp       <= `RESP_OKAY;
      end else begin
         if (awvalid & awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= awaddr;
            awready     <= 1'b0;
         end else if (~aw_full_reg & ~bvalid) begin
            awready     <= 1'b1;
         end
         if (wvalid & wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= wdata[7:0];
            w_lane_reg <= wstrb[0];
            wready     <= 1'b0;
         end else if (~w_full_reg & ~bvalid) begin
            wready     <= 1'b1;
         end
         if (wr_fire) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            bvalid      <= 1'b1;
            bresp       <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid & bready) begin
            bvalid      <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // axi read channel
   // ----------------------------------------
   // one read at a time; the value is latched at the address handshake
   always @(posedge clk_sys) begin
      if (reset) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `RESP_OKAY;
      end else begin
         if (arvalid & arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_ok ? reg_value(eff_idx(rd_idx)) : `BYTE_ZERO};
            rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid & rready) begin
            rvalid  <= 1'b0;
         end else if (~rvalid) begin
            arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // interrupt control and flags
   // ----------------------------------------
   // software write first, hardware events last so a set in the clear cycle wins
   always @(posedge clk_sys) begin
      if (reset) begin
         irq_control_reg   <= `IRQ_CTRL_RESET;
         periph_flag_reg   <= `BYTE_ZERO;
         periph_enable_reg <= `BYTE_ZERO;
         option_reg        <= `OPTION_RESET;
         ext_prev_reg      <= 1'b0;
         pins_prev_reg     <= 3'b000;
         primed_reg        <= 1'b0;
      end else begin
         ext_prev_reg  <= ext_irq_pin;
         pins_prev_reg <= pins_now;
         primed_reg    <= 1'b1;
         if (wr_ctrl) begin
            irq_control_reg <= w_data_reg;
         end
         if (wr_pflag) begin
            periph_flag_reg <= w_data_reg;
         end
         if (wr_en & (wr_eff == `IDX_PENABLE)) begin
            periph_enable_reg <= w_data_reg;
         end
         if (wr_en & (wr_eff == `IDX_OPTION)) begin
            option_reg <= w_data_reg;
         end
         // vectoring masks further interrupts until the interrupt return
         if (irq_take) begin
            irq_control_reg[`GLOBAL_EN_BIT] <= 1'b0;
         end else if (return_from_irq_instr) begin
            irq_control_reg[`GLOBAL_EN_BIT] <= 1'b1;
         end
         // flags rise on events whatever the enables say
         if (timer_ovf_event) begin
            irq_control_reg[`TIMER_FLAG_BIT] <= 1'b1;
         end
         if (ext_evt) begin
            irq_control_reg[`EXT_FLAG_BIT] <= 1'b1;
         end
         if (pin_chg) begin
            irq_control_reg[`CHANGE_FLAG_BIT] <= 1'b1;
         end
         periph_flag_reg <= (wr_pflag ? w_data_reg : periph_flag_reg) | periph_flag_set;
      end
   end

   // ----------------------------------------
   // interrupt request and pin outputs
   // ----------------------------------------
   // registered, so the request follows a flag or enable change by one cycle
   always @(posedge clk_sys) begin
      if (reset) begin
         irq_request        <= 1'b0;
         weak_pullup_enable <= 3'b000;
      end else begin
         irq_request <= irq_control_reg[`GLOBAL_EN_BIT] & (
                        (irq_control_reg[`TIMER_EN_BIT] & irq_control_reg[`TIMER_FLAG_BIT]) |
                        (irq_control_reg[`EXT_EN_BIT] & irq_control_reg[`EXT_FLAG_BIT]) |
                        (irq_control_reg[`CHANGE_EN_BIT] & irq_control_reg[`CHANGE_FLAG_BIT]) |
                        (irq_control_reg[`PERIPH_EN_BIT] &
                         (|(periph_enable_reg & periph_flag_reg))));
         // pull-ups enable on a low option bit; clear-pin mode keeps pin three up
         weak_pullup_enable <= {~option_reg[`PULLUP_OFF_BIT] | master_clear_select,
                                ~option_reg[`PULLUP_OFF_BIT],
                                ~option_reg[`PULLUP_OFF_BIT]};
      end
   end

   // ----------------------------------------
   // program counter and return stack
   // ----------------------------------------
   // priority: vector, call, jump, return, low byte write, step
   // no stack action touches the holding register, and wrap is silent
   always @(posedge clk_sys) begin
      if (reset) begin
         pc_reg               <= `PC_RESET;
         pc_value             <= `PC_RESET;
         stack_ptr_reg        <= 3'd0;
         pc_high_holding_reg  <= 5'd0;
         indirect_pointer_reg <= `BYTE_ZERO;
         for (i = 0; i < 8; i = i + 1) begin
            stack_mem[i] <= `PC_RESET;
         end
      end else begin
         if (wr_en & (wr_eff == `IDX_PC_HIGH)) begin
            pc_high_holding_reg <= w_data_reg[4:0];
         end
         if (wr_en & (wr_eff == `IDX_POINTER)) begin
            indirect_pointer_reg <= w_data_reg;
         end
         if (irq_take) begin
            stack_mem[stack_ptr_reg] <= pc_reg;
            stack_ptr_reg            <= stack_ptr_reg + 3'd1;
            pc_reg                   <= `IRQ_VECTOR;
            pc_value                 <= `IRQ_VECTOR;
         end else if (call_instr) begin
            // paging bits feed the top two bits; one page, so they only reach the counter
            stack_mem[stack_ptr_reg] <= pc_reg + 13'd1;
            stack_ptr_reg            <= stack_ptr_reg + 3'd1;
            pc_reg                   <= {pc_high_holding_reg[4:3], branch_target};
            pc_value                 <= {pc_high_holding_reg[4:3], branch_target};
         end else if (jump_instr) begin
            pc_reg   <= {pc_high_holding_reg[4:3], branch_target};
            pc_value <= {pc_high_holding_reg[4:3], branch_target};
         end else if (do_return) begin
            pc_reg        <= stack_mem[sp_dec];
            pc_value      <= stack_mem[sp_dec];
            stack_ptr_reg <= sp_dec;
         end else if (wr_pc_low) begin
            pc_reg   <= {pc_high_holding_reg, w_data_reg};
            pc_value <= {pc_high_holding_reg, w_data_reg};
         end else if (instr_step) begin
            pc_reg   <= pc_reg + 13'd1;
            pc_value <= pc_reg + 13'd1;
         end
      end
   end

endmodule
`default_nettype wire

// ---- tb/irq_source_model.sv ----
// behavioural model of the timer, pin and peripheral event sources
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
   input  wire logic       clk_sys,
   input  wire logic       tmr_cmd,
   input  wire logic       ext_cmd,
   input  wire logic [7:0] per_cmd,
   input  wire logic [2:0] pin_cmd,
   output logic            timer_ovf_event,
   output logic            ext_irq_pin,
   output logic [7:0]      periph_flag_set,
   output logic            pin_zero,
   output logic            pin_one,
   output logic            pin_three
);
   // events and pin levels leave the source one edge after the command;
   // the commands start at zero, so the sources are quiet from the first edge of reset
   always @(posedge clk_sys) begin
      timer_ovf_event <= tmr_cmd;
      periph_flag_set <= per_cmd;
      ext_irq_pin <= ext_cmd;
      {pin_three, pin_one, pin_zero} <= pin_cmd;
   end
endmodule
`default_nettype wire

// ---- tb/core_irq_chk.sv ----
// concurrent checks on the ports of the core control block
`timescale 1ns/1ps
`default_nettype none
module core_irq_chk (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [1:0]  bresp,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic        call_instr,
   input wire logic        jump_instr,
   input wire logic        return_instr,
   input wire logic        return_literal_instr,
   input wire logic        return_from_irq_instr,
   input wire logic        irq_take,
   input wire logic        instr_step,
   input wire logic [10:0] branch_target,
   input wire logic        master_clear_select,
   input wire logic [12:0] pc_value,
   input wire logic        irq_request,
   input wire logic [2:0]  weak_pullup_enable
);
   // ---
   // one clock domain, reset masks everything but the reset check
   // ---
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   chk_reset_clears_pc: assert property (disable iff (1'b0) reset |=> pc_value == 13'h0000 && !irq_request)
      else $error("reset left pc or request set");
   chk_irq_vector: assert property (irq_take |=> pc_value == 13'h0004)
      else $error("interrupt did not vector");
   chk_irq_masks_after: assert property (irq_take ##1 (!return_from_irq_instr && !awvalid) |=> !irq_request)
      else $error("request stayed after vectoring");
   chk_call_target: assert property (call_instr && !irq_take |=> pc_value[10:0] == $past(branch_target))
      else $error("call target not loaded");
   chk_jump_target: assert property (jump_instr && !irq_take && !call_instr |=> pc_value[10:0] == $past(branch_target))
      else $error("jump target not loaded");
   // a return right after a call must land on the address after the call
   chk_call_return: assert property (call_instr && !irq_take ##1 return_instr && !irq_take && !call_instr
      && !jump_instr |=> pc_value == $past(pc_value, 2) + 13'h0001)
      else $error("return after call went astray");
   // awready high means no bus write of the low byte lands at this edge
   chk_pc_step: assert property (instr_step && awready && !(irq_take || call_instr || jump_instr
      || return_instr || return_literal_instr || return_from_irq_instr) |=> pc_value == $past(pc_value) + 13'h0001)
      else $error("step did not advance pc");
   chk_pullup_clear: assert property (master_clear_select && !$past(reset) |=> weak_pullup_enable[2])
      else $error("clear pin pull-up off");
   chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
endmodule
bind core_irq_pc_stack_indirect core_irq_chk u_core_irq_chk (.*);
`default_nettype wire

// ---- tb/core_irq_pc_stack_indirect_tb.sv ----
// self-checking testbench for the core control block
`timescale 1ns/1ps
`default_nettype none
module core_irq_pc_stack_indirect_tb;
   logic        clk_sys = 0, reset = 1, master_clear_select = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
   logic [2:0]  awprot = 0, arprot = 0, pin_cmd = 0;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [6:0]  op = 0;           // one strobe bit per instruction kind
   logic [10:0] branch_target = 0;
   logic        tmr_cmd = 0, ext_cmd = 0;
   logic [7:0]  per_cmd = 0;
   wire         awready, wready, bvalid, arready, rvalid, irq_request;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [12:0] pc_value;
   wire  [2:0]  weak_pullup_enable;
   wire         timer_ovf_event, ext_irq_pin, pin_zero, pin_one, pin_three;
   wire  [7:0]  periph_flag_set;
   wire call_instr = op[0], jump_instr = op[1], return_instr = op[2], return_literal_instr = op[3];
   wire return_from_irq_instr = op[4], irq_take = op[5], instr_step = op[6];
   int          mismatches = 0, check_count = 0, cycles = 0;
   logic [12:0] stk [8];          // reference return stack, wraps like the design
   logic [2:0]  sp = 0;
   logic [12:0] pc_exp = 0;
   logic [4:0]  hold = 0;
   logic [33:0] got;
   core_irq_pc_stack_indirect u_core_irq_pc_stack_indirect (.*);
   irq_source_model u_irq_source_model (.*);
   always #2.5 clk_sys = ~clk_sys;
   // ---
   // shared tasks
   // ---
   task summarize;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task cmp(input [33:0] g, input [33:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // bready only after bvalid, so the response must stand while we stall
   task wr(input [7:0] idx, input [7:0] d);
      @(posedge clk_sys);
      awaddr <= {22'h0, idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b1;
      @(posedge clk_sys);
      got = {32'h0000_0000, bresp};
      bready <= 1'b0;
   endtask
   task rd(input [7:0] idx);
      @(posedge clk_sys);
      araddr <= {22'h0, idx, 2'b00};
      arvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b1;
      @(posedge clk_sys);
      got = {rresp, rdata};
      rready <= 1'b0;
   endtask
   task rc(input [7:0] idx, input [7:0] e);
      rd(idx);
      cmp(got, {26'h0, e});
   endtask
   // events land in the flags a few edges after the command
   task src(input t, input [7:0] p, input x, input [2:0] g);
      @(posedge clk_sys);
      {tmr_cmd, per_cmd, ext_cmd, pin_cmd} <= {t, p, x, g};
      @(posedge clk_sys);
      {tmr_cmd, per_cmd} <= 9'h000;
      repeat (3) @(posedge clk_sys);
   endtask
   // one instruction strobe, then pc against the reference stack
   task go(input int i, input [10:0] t);
      @(posedge clk_sys);
      branch_target <= t;
      op <= 7'h01 << i;
      @(posedge clk_sys);
      op <= 7'h00;
      #1;
      if (i == 0 || i == 5) begin
         stk[sp] = (i == 0) ? pc_exp + 13'h0001 : pc_exp;
         sp = sp + 3'd1;
      end
      if (i >= 2 && i <= 4) begin
         sp = sp - 3'd1;
         pc_exp = stk[sp];
      end
      if (i <= 1) pc_exp = {hold[4:3], t};
      if (i == 5) pc_exp = 13'h0004;
      if (i == 6) pc_exp = pc_exp + 13'h0001;
      cmp(pc_value, pc_exp);
   endtask
   // hang guard well above the few hundred cycles the sequence needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         summarize;
      end
   end
   // ---
   // main sequence
   // ---
   initial begin
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      rc(8'h0B, 8'h00);
      cmp(pc_value, 13'h0000);
      wr(8'h0B, 8'hF8);
      rc(8'h0B, 8'hF8);
      wr(8'h0B, 8'h00);
      src(1, 0, 0, 0);
      rc(8'h0B, 8'h04);
      cmp(irq_request, 1'b0);
      wr(8'h0B, 8'hA4);
      repeat (2) @(posedge clk_sys);
      cmp(irq_request, 1'b1);
      wr(8'h0B, 8'h24);
      repeat (2) @(posedge clk_sys);
      cmp(irq_request, 1'b0);
      wr(8'h0B, 8'hA4);
      go(5, 0);
      rc(8'h0B, 8'h24);
      go(4, 0);
      rc(8'h0B, 8'hA4);
      wr(8'h0B, 8'h00);
      src(0, 0, 1, 0);
      rc(8'h0B, 8'h02);
      wr(8'h81, 8'hBF);
      wr(8'h0B, 8'h00);
      src(0, 0, 0, 0);
      rc(8'h0B, 8'h02);
      wr(8'h0B, 8'h00);
      src(0, 0, 0, 3'b010);
      rc(8'h0B, 8'h01);
      wr(8'h0B, 8'h00);
      master_clear_select <= 1'b1;
      src(0, 0, 0, 3'b110);
      rc(8'h0B, 8'h00);
      rc(8'h91, 8'h02);
      cmp(weak_pullup_enable, 3'b100);
      src(0, 8'h01, 0, 3'b110);
      rc(8'h0C, 8'h01);
      wr(8'h8C, 8'h01);
      wr(8'h0B, 8'h80);
      repeat (2) @(posedge clk_sys);
      cmp(irq_request, 1'b0);
      wr(8'h0B, 8'hC0);
      repeat (2) @(posedge clk_sys);
      cmp(irq_request, 1'b1);
      wr(8'h0B, 8'h00);
      wr(8'h0A, 8'h1F);
      hold = 5'h1F;
      wr(8'h02, 8'h34);
      pc_exp = 13'h1F34;
      cmp(pc_value, pc_exp);
      rc(8'h02, 8'h34);
      for (int k = 0; k < 10; k++) go(0, 11'h100 + 11'(k));
      rc(8'h0A, 8'h1F);
      for (int k = 0; k < 10; k++) go(2 + k % 3, 0);
      go(1, 11'h7FF);
      go(6, 0);
      // call and return on back-to-back edges come home to the word after the call
      @(posedge clk_sys);
      branch_target <= 11'h123;
      op <= 7'h01;
      @(posedge clk_sys);
      op <= 7'h04;
      @(posedge clk_sys);
      op <= 7'h00;
      #1;
      pc_exp = pc_exp + 13'h0001;
      cmp(pc_value, pc_exp);
      wr(8'h04, 8'h0A);
      wr(8'h00, 8'h05);
      rc(8'h0A, 8'h05);
      rc(8'h00, 8'h05);
      wr(8'h04, 8'h00);
      wr(8'h00, 8'h55);
      cmp(got, {32'h0000_0000, 2'b00});
      rc(8'h00, 8'h00);
      rc(8'h0A, 8'h05);
      rd(8'h55);
      cmp(got, {2'b10, 32'h0});
      wr(8'h55, 8'h00);
      cmp(got, {32'h0000_0000, 2'b10});
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      #1;
      cmp(pc_value, 13'h0000);
      summarize;
   end
endmodule
`default_nettype wire
